// *** verilog/power_down_strobe_timing.sv ***
// Power-down strobe sequencer: wake pin watch, gap timing, strobes and rail shut-off.
`timescale 1ns/100ps
// Functional notes
// RL1 - third-to-fourth gap: 6, 12, 24, 48 ms
// RL2 - second-to-third gap: 6, 12, 24, 48 ms
// RL3 - first-to-second gap: 6, 12, 24, 48 ms
// RL4 - first strobe 3 or 6 ms after wake low
// RL5 - later gaps scaled by 1 or 16
// RL6 - each rail off on its selected strobe
// RL7 - strobes ascend; restart only on new wake fall
module power_down_strobe_timing
    import pd_seq_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEFAULT
)(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic wake_request_pin_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic step_one_pulse_o,
    output logic step_two_pulse_o,
    output logic step_three_pulse_o,
    output logic step_four_pulse_o,
    output logic [NUM_RAILS-1:0] rail_off_o,
    output logic seq_busy_o
);

    // Configuration registers.
    delay_cfg_t power_down_delay_config;
    delay_cfg_t next_delay_cfg;
    order_cfg_t power_down_order_config;
    order_cfg_t next_order_cfg;
    logic [7:0] next_rdata;

    // Wake pin synchroniser and edge history.
    logic wake_meta;
    logic wake_sync;
    logic wake_prev;
    logic wake_fall;
    logic wake_rise;

    // Sequencer state.
    seq_state_t state;
    seq_state_t next_state;
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic [NUM_STEPS-1:0] step_pulse;
    logic [NUM_STEPS-1:0] next_step_pulse;
    logic [NUM_RAILS-1:0] next_rail_off;
    logic [NUM_RAILS-1:0] rail_hit;
    logic [1:0] rail_order [NUM_RAILS];

    // Timer handshake.
    logic timer_load;
    logic [MS_W-1:0] load_ms;
    logic timer_done;
    logic step_fire;

    // Length of a later gap in ms from its code and the scale bit.
    function automatic logic [MS_W-1:0] gap_ms(input logic [1:0] code, input logic scale);
        logic [MS_W-1:0] base;
        base = GAP_BASE_MS << code;
        gap_ms = scale ? (base << SCALE_SHIFT) : base;
    endfunction : gap_ms

    // Register writes and registered read data; unmapped reads return zero.
    always_comb
    begin
        next_delay_cfg = power_down_delay_config;
        next_order_cfg = power_down_order_config;
        next_rdata = reg_rdata_o;
        if (reg_wr_i && reg_addr_i == DELAY_CFG_ADDR)
        begin
            next_delay_cfg = delay_cfg_t'(reg_wdata_i);
        end
        if (reg_wr_i && reg_addr_i == ORDER_CFG_ADDR)
        begin
            next_order_cfg = order_cfg_t'(reg_wdata_i);
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                DELAY_CFG_ADDR: next_rdata = power_down_delay_config;
                ORDER_CFG_ADDR: next_rdata = power_down_order_config;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register file storage.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            power_down_delay_config <= delay_cfg_t'(DELAY_CFG_RESET);
            power_down_order_config <= order_cfg_t'(ORDER_CFG_RESET);
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            power_down_delay_config <= next_delay_cfg;
            power_down_order_config <= next_order_cfg;
            reg_rdata_o <= next_rdata;
        end
    end

    // Two-flop synchroniser on the wake pin, then a third flop for edges.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
            wake_prev <= 1'b0;
        end
        else
        begin
            wake_meta <= wake_request_pin_i;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
        end
    end

    // Edges are taken only from the synchronised copies.
    assign wake_fall = wake_prev && !wake_sync;
    assign wake_rise = wake_sync && !wake_prev;

    // Per-rail strobe selects, unpacked in rail order from the top field down.
    assign rail_order[3] = power_down_order_config.gate_high_pump_off_order;
    assign rail_order[2] = power_down_order_config.pos_regulator_off_order;
    assign rail_order[1] = power_down_order_config.gate_low_pump_off_order;
    assign rail_order[0] = power_down_order_config.neg_regulator_off_order;

    // A strobe is issued when the running gap expires.
    assign step_fire = timer_done && state == SEQ_RUN;

    // Rail hit detection, one comparator per rail.
    for (genvar r = 0; r < NUM_RAILS; r++)
    begin : g_rail
        // RL6 rail off match
        assign rail_hit[r] = step_fire && idx == rail_order[r];
    end

    // Sequencer next state: which gap to load, which strobe to fire.
    always_comb
    begin
        next_state = state;
        next_idx = idx;
        next_step_pulse = '0;
        next_rail_off = rail_off_o;
        timer_load = 1'b0;
        load_ms = '0;
        if (wake_rise)
        begin
            // Wake high again cancels the sequence and lets the rails back on.
            next_state = SEQ_IDLE;
            next_idx = 2'h0;
            next_rail_off = '0;
        end
        else if (wake_fall)
        begin
            // RL4 first gap select
            timer_load = 1'b1;
            load_ms = power_down_delay_config.gap_wake_to_first ? FIRST_LONG_MS : FIRST_SHORT_MS;
            next_state = SEQ_RUN;
            next_idx = 2'h0;
        end
        else
        begin
            unique case (state)
                SEQ_IDLE, SEQ_DONE:
                begin
                    // Waiting for the next wake fall.
                    next_idx = idx;
                end
                SEQ_RUN:
                begin
                    if (step_fire)
                    begin
                        // RL7 ascending strobe order
                        next_step_pulse = NUM_STEPS'(1) << idx;
                        next_rail_off = rail_off_o | rail_hit;
                        if (idx == 2'h3)
                        begin
                            next_state = SEQ_DONE;
                        end
                        else
                        begin
                            next_idx = idx + 2'h1;
                            timer_load = 1'b1;
                            // RL5 scale on later gaps
                            unique case (idx)
                                // RL3 first-to-second gap
                                2'h0: load_ms = gap_ms(power_down_delay_config.gap_first_to_second,
                                                       power_down_delay_config.gap_scale_select);
                                // RL2 second-to-third gap
                                2'h1: load_ms = gap_ms(power_down_delay_config.gap_second_to_third,
                                                       power_down_delay_config.gap_scale_select);
                                // RL1 third-to-fourth gap
                                default: load_ms = gap_ms(power_down_delay_config.gap_third_to_fourth,
                                                          power_down_delay_config.gap_scale_select);
                            endcase
                        end
                    end
                end
                default:
                begin
                    next_state = SEQ_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= SEQ_IDLE;
            idx <= 2'h0;
            step_pulse <= '0;
            rail_off_o <= '0;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
            step_pulse <= next_step_pulse;
            rail_off_o <= next_rail_off;
        end
    end

    // Single timebase for every gap.
    gap_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_gap_timer (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .load_i(timer_load),
        .load_ms_i(load_ms),
        .abort_i(wake_rise),
        .done_o(timer_done)
    );

    // Strobe outputs and busy flag.
    assign step_one_pulse_o = step_pulse[0];
    assign step_two_pulse_o = step_pulse[1];
    assign step_three_pulse_o = step_pulse[2];
    assign step_four_pulse_o = step_pulse[3];
    assign seq_busy_o = (state == SEQ_RUN);

    // Expected next strobe, tracked for the ordering check.
    logic [NUM_STEPS-1:0] expect_mask;
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            expect_mask <= 4'h1;
        else if (wake_fall)
            expect_mask <= 4'h1;
        else if (step_pulse != '0)
            expect_mask <= step_pulse << 1;
    end

    a_first_gap: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL4
        wake_fall |-> load_ms == (power_down_delay_config.gap_wake_to_first ? 10'h006 : 10'h003))
        else $error("first gap length wrong");

    a_gap_second: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL3
        (step_fire && idx == 2'h0 && !wake_rise && !power_down_delay_config.gap_scale_select)
        |-> timer_load && load_ms == (10'h006 << power_down_delay_config.gap_first_to_second))
        else $error("first-to-second gap wrong");

    a_gap_third: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL2
        (step_fire && idx == 2'h1 && !wake_rise && !power_down_delay_config.gap_scale_select)
        |-> load_ms == (10'h006 << power_down_delay_config.gap_second_to_third))
        else $error("second-to-third gap wrong");

    a_gap_fourth: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL1
        (step_fire && idx == 2'h2 && !wake_rise && !power_down_delay_config.gap_scale_select)
        |-> load_ms == (10'h006 << power_down_delay_config.gap_third_to_fourth))
        else $error("third-to-fourth gap wrong");

    a_gap_scaled: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL5
        (timer_load && !wake_fall && power_down_delay_config.gap_scale_select)
        |-> load_ms[3:0] == 4'h0 && load_ms >= 10'h060)
        else $error("later gap not scaled by sixteen");

    a_rail_off: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL6
        (rail_off_o[3] && !$past(rail_off_o[3])) |-> step_pulse[$past(rail_order[3])])
        else $error("rail switched off on wrong strobe");

    a_step_order: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RL7
        (step_pulse != '0) |-> step_pulse == expect_mask ##1 (step_pulse == '0))
        else $error("strobe out of order");

endmodule : power_down_strobe_timing

// *** verilog/pd_seq_pkg.sv ***
// Shared constants, field layouts and state codes for the power-down strobe timer.
package pd_seq_pkg;

    // Register offsets on the register port.
    localparam logic [7:0] ORDER_CFG_ADDR = 8'h0B;
    localparam logic [7:0] DELAY_CFG_ADDR = 8'h0C;

    // Reset values of the two registers.
    localparam logic [7:0] ORDER_CFG_RESET = 8'h1E;
    localparam logic [7:0] DELAY_CFG_RESET = 8'hE4;

    // Layout of the delay register, most significant field first.
    typedef struct packed {
        logic [1:0] gap_third_to_fourth;
        logic [1:0] gap_second_to_third;
        logic [1:0] gap_first_to_second;
        logic gap_wake_to_first;
        logic gap_scale_select;
    } delay_cfg_t;

    // Layout of the order register, one 2-bit strobe select per rail.
    typedef struct packed {
        logic [1:0] gate_high_pump_off_order;
        logic [1:0] pos_regulator_off_order;
        logic [1:0] gate_low_pump_off_order;
        logic [1:0] neg_regulator_off_order;
    } order_cfg_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_DONE = 2'b10
    } seq_state_t;

    // Counts of rails and strobes.
    localparam int NUM_RAILS = 4;
    localparam int NUM_STEPS = 4;

    // Width of a delay expressed in milliseconds; the longest is 48 ms times 16.
    localparam int MS_W = 10;

    // Delay figures in milliseconds.
    localparam logic [MS_W-1:0] GAP_BASE_MS = 10'h006;
    localparam logic [MS_W-1:0] FIRST_SHORT_MS = 10'h003;
    localparam logic [MS_W-1:0] FIRST_LONG_MS = 10'h006;
    localparam int SCALE_SHIFT = 4;

    // Clock period and one millisecond, both in nanoseconds.
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;

    // Clock cycles in one millisecond, rounded up.
    localparam int MS_CYCLES_DEFAULT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pd_seq_pkg

// *** verilog/gap_timer.sv ***
// Millisecond timebase and down counter that times one gap between strobes.
`timescale 1ns/100ps
module gap_timer
    import pd_seq_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEFAULT
)(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [MS_W-1:0] load_ms_i,
    input wire logic abort_i,
    output logic done_o
);

    // The prescaler needs at least one cycle per millisecond.
    if (MS_CYCLES < 1)
    begin : g_bad_ms
        $error("gap_timer: MS_CYCLES must be at least one");
    end

    // Prescaler position inside the current millisecond.
    logic [31:0] pre;
    logic [31:0] next_pre;
    // Whole milliseconds left; zero means idle.
    logic [MS_W-1:0] ms_left;
    logic [MS_W-1:0] next_ms_left;
    // One-cycle pulse when the gap has run out.
    logic next_done;
    // Prescaler wraps on this cycle.
    logic ms_tick;

    // Next-state logic: a load restarts the millisecond grid so the gap is exact.
    always_comb
    begin
        ms_tick = (pre == 32'(MS_CYCLES - 1));
        next_pre = pre;
        next_ms_left = ms_left;
        next_done = 1'b0;
        if (abort_i)
        begin
            // Abort drops any gap in flight.
            next_pre = 32'h00000000;
            next_ms_left = '0;
        end
        else if (load_i)
        begin
            next_pre = 32'h00000000;
            next_ms_left = load_ms_i;
        end
        else if (ms_left != '0)
        begin
            // Count cycles, then milliseconds.
            next_pre = ms_tick ? 32'h00000000 : pre + 32'h00000001;
            if (ms_tick)
            begin
                next_ms_left = ms_left - 1'b1;
                next_done = (ms_left == MS_W'(1));
            end
        end
    end

    // Registers of the timer.
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre <= 32'h00000000;
            ms_left <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            pre <= next_pre;
            ms_left <= next_ms_left;
            done_o <= next_done;
        end
    end

endmodule : gap_timer

// *** dv/pd_host_model.sv ***
// Host-side model that drives the wake pin and the register port of the sequencer.
`timescale 1ns/100ps
module pd_host_model (
    input wire logic mclk_i,
    output logic wake_o,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    // Idle bus: strobes low, wake high so no falling edge is seen at reset release.
    initial
    begin
        wake_o = 1'b1;
        addr_o = 8'hFF;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // One write, held for exactly the edge that takes it; released values are inverted.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i) #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge mclk_i) #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : write_reg

    // One read; the data is registered at the taking edge and collected one edge later.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i) #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge mclk_i) #1;
        rd_o = 1'b0;
        addr_o = ~a;
        @(posedge mclk_i);
        d = rdata_i;
    endtask : read_reg

    // Moves the wake pin just after a clock edge.
    task automatic set_wake(input logic v);
        @(posedge mclk_i) #1;
        wake_o = v;
    endtask : set_wake
endmodule : pd_host_model

// *** dv/power_down_strobe_timing_tb_top.sv ***
// Self-checking testbench for the power-down strobe sequencer.
`timescale 1ns/100ps
module power_down_strobe_timing_tb_top;
    import pd_seq_pkg::*;
    // Short millisecond so the longest scaled sequence stays a few thousand cycles.
    localparam int MSC = 4;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wake, wr, rd;
    logic [7:0] addr, wdata, rdata;
    logic s1, s2, s3, s4, busy;
    logic [3:0] rail_off;
    logic [3:0] pulses;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int ns = 0;
    int st[4];
    logic [3:0] rails[4];
    // Delay and order settings swept by the sequence tests.
    logic [7:0] dl[5] = '{8'h00, 8'h56, 8'hA8, 8'hFE, 8'h1B};
    logic [7:0] ol[5] = '{8'h1B, 8'hE4, 8'h00, 8'hFF, 8'h8D};

    // Clock generator.
    always #12.5 mclk_i = ~mclk_i;

    power_down_strobe_timing #(.MS_CYCLES(MSC)) dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .wake_request_pin_i(wake), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .step_one_pulse_o(s1), .step_two_pulse_o(s2), .step_three_pulse_o(s3),
        .step_four_pulse_o(s4), .rail_off_o(rail_off), .seq_busy_o(busy)
    );

    pd_host_model host (
        .mclk_i(mclk_i), .wake_o(wake), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata)
    );

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // Strobe monitor: records the time of each strobe and the rails seen with it.
    always @(posedge mclk_i)
    begin
        cyc = cyc + 1;
        pulses = {s4, s3, s2, s1};
        if (pulses !== 4'h0)
        begin
            check(32'(pulses), 32'(4'h1 << ns), "strobe order");
            if (pulses === 4'h1)
                check(32'(busy), 32'h1, "busy at step one");
            if (ns < 4)
            begin
                st[ns] = cyc;
                rails[ns] = rail_off;
            end
            ns = ns + 1;
        end
    end

    // Waits for a given strobe count, bounded.
    task automatic wait_steps(input int n);
        for (int i = 0; i < 20000 && ns < n; i++)
            @(posedge mclk_i);
        #1;
        check(32'(ns), 32'(n), "strobe count");
    endtask : wait_steps

    // Runs one full power-down with the given delay and order settings.
    task automatic run_seq(input logic [7:0] dcfg, input logic [7:0] ocfg);
        int w, g, d;
        logic [7:0] rb;
        logic [3:0] exp_r;
        host.write_reg(DELAY_CFG_ADDR, dcfg);
        host.write_reg(ORDER_CFG_ADDR, ocfg);
        host.read_reg(DELAY_CFG_ADDR, rb);
        check(32'(rb), 32'(dcfg), "delay readback");
        host.read_reg(ORDER_CFG_ADDR, rb);
        check(32'(rb), 32'(ocfg), "order readback");
        ns = 0;
        host.set_wake(1'b0);
        w = cyc;
        wait_steps(4);
        g = dcfg[1] ? 6 : 3;
        d = st[0] - w;
        check(32'(d >= g * MSC + 1 && d <= g * MSC + 8), 32'h1, "first gap");
        for (int k = 1; k < 4; k++)
        begin
            g = (6 << dcfg[2*k+:2]) << (dcfg[0] ? 4 : 0);
            d = st[k] - st[k-1];
            check(32'(d >= g * MSC && d <= g * MSC + 2), 32'h1, "later gap");
        end
        for (int k = 0; k < 4; k++)
        begin
            for (int r = 0; r < 4; r++)
                exp_r[r] = (ocfg[2*r+:2] <= k);
            check(32'(rails[k]), 32'(exp_r), "rails at strobe");
        end
        // Wake stays low: nothing may start again.
        repeat (60) @(posedge mclk_i);
        #1;
        check(32'(ns), 32'h4, "no restart while low");
        check(32'(rail_off), 32'hF, "rails held off");
        check(32'(busy), 32'h0, "idle after step four");
        host.set_wake(1'b1);
        repeat (6) @(posedge mclk_i);
        #1;
        check(32'(rail_off), 32'h0, "rails back on");
        $display("Sequence delay %0h order %0h done", dcfg, ocfg);
    endtask : run_seq

    // Main sequence of tests.
    initial
    begin
        logic [7:0] rb;
        repeat (20) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        host.read_reg(DELAY_CFG_ADDR, rb);
        check(32'(rb), 32'(DELAY_CFG_RESET), "delay reset value");
        host.read_reg(ORDER_CFG_ADDR, rb);
        check(32'(rb), 32'(ORDER_CFG_RESET), "order reset value");
        host.write_reg(8'h0D, 8'h5A);
        host.read_reg(8'h0D, rb);
        check(32'(rb), 32'h0, "unmapped read");
        host.read_reg(DELAY_CFG_ADDR, rb);
        check(32'(rb), 32'(DELAY_CFG_RESET), "unmapped write ignored");
        $display("Register test done");
        for (int i = 0; i < 5; i++)
            run_seq(dl[i], ol[i]);
        // Abort after step two, then a clean restart on a new falling edge.
        host.write_reg(DELAY_CFG_ADDR, 8'h00);
        host.write_reg(ORDER_CFG_ADDR, 8'h1B);
        ns = 0;
        host.set_wake(1'b0);
        wait_steps(2);
        host.set_wake(1'b1);
        repeat (100) @(posedge mclk_i);
        #1;
        check(32'(ns), 32'h2, "no strobe after abort");
        check(32'(rail_off), 32'h0, "rails on after abort");
        check(32'(busy), 32'h0, "idle after abort");
        $display("Abort test done");
        run_seq(8'h03, 8'h1B);
        finish_test();
    end

    // Watchdog sized well above the expected run of about six thousand cycles.
    initial
    begin
        repeat (60000) @(posedge mclk_i);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule : power_down_strobe_timing_tb_top
